// ===== common/kxs_regs.svh
// Purpose: register offsets, field positions, reset values and codes of the error statistics bank
// Assumes: included by bare name
// Notes:   management addresses are 16-bit register numbers within device 0x01
`ifndef KXS_REGS_SVH
`define KXS_REGS_SVH

// management register numbers
`define KXS_ADDR_LN2_EOP     16'h8012
`define KXS_ADDR_LN3_EOP     16'h8013
`define KXS_ADDR_TX_DROP     16'h8014
`define KXS_ADDR_TX_INSERT   16'h8015
`define KXS_ADDR_RX_DROP     16'h8016
`define KXS_ADDR_RX_INSERT   16'h8017
`define KXS_ADDR_STATUS      16'h8018
`define KXS_NUM_TALLIES      6
`define KXS_DEVAD            5'h01

// reset values
`define KXS_TALLY_RESET      16'hFFFD
`define KXS_STATUS_RESET     16'h0000
`define KXS_TALLY_MAX        16'hFFFF
`define KXS_UNMAPPED_DATA    16'h0000

// status word field positions
`define KXS_ST_SYNC_BIT      15
`define KXS_ST_RSVD_HI       14
`define KXS_ST_RSVD_LO       6
`define KXS_ST_SCOL_BIT      5
`define KXS_ST_TCOL_BIT      4

// column codes
`define KXS_CODE_TERM        8'hFD
`define KXS_CODE_IDLE        8'h07
`define KXS_CODE_K           8'hBC
`define KXS_CODE_A           8'h7C

// management frame timing, counted in management clock bits
`define KXS_PREAMBLE_LEN     6'h20
`define KXS_HDR_LAST         4'hD
`define KXS_DATA_LAST        4'hF
`define KXS_OP_ADDR          2'h0
`define KXS_OP_WRITE         2'h1
`define KXS_OP_READ_INC      2'h2
`define KXS_OP_READ          2'h3

`endif

// ===== common/kxs_pkg.sv
// Purpose: shared types of the error statistics bank
// Assumes: nothing
// Notes:   constants live in kxs_regs.svh
package kxs_pkg;

    typedef logic [15:0] kxs_word_t;

    typedef enum logic [1:0] {
        MDIO_PRE,
        MDIO_HDR,
        MDIO_TA,
        MDIO_DATA
    } kxs_mdio_state_t;

endpackage : kxs_pkg

// ===== core/kxs_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module kxs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule : kxs_sync

// ===== core/kxs_sat_counter.sv
// Purpose: 16-bit saturating clear-on-read event tally
// Assumes: inc and clr are one-cycle pulses on sys_clk
// Notes:   an event in the clearing cycle is kept as a count of one
`timescale 1ns/1ps
`include "kxs_regs.svh"
module kxs_sat_counter (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              inc,
    input  wire logic              clr,
    output kxs_pkg::kxs_word_t     count
);
    import kxs_pkg::*;

    kxs_word_t next_count;

    always_comb begin
        if (clr) begin
            next_count = inc ? 16'h0001 : 16'h0000;
        end else if (inc && count != `KXS_TALLY_MAX) begin
            next_count = count + 16'h0001;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= `KXS_TALLY_RESET;
        end else begin
            count <= next_count;
        end
    end

endmodule : kxs_sat_counter

// ===== core/kxs_error_stats.sv
// Purpose: end-of-packet, idle drop/insert tallies and error status word behind a management port
// Assumes: one column per colValid on sys_clk; event inputs are sys_clk pulses
// Notes:   management clock and data are pins, sampled through two flops
// Functional notes
// - A terminate in lane 2 counts one lane 2 error if lane 3 is not K or the next column is neither K nor A.
// - For lane 2, a terminate not followed by K in the remaining lane of its column is an error.
// - A terminate in lane 3 counts a lane 3 error only if the next column is neither K nor A.
// - Each end-of-packet tally returns its value on a read and that read reloads it with 0, or with 1 if an error is counted in the same cycle.
// - Every idle dropped by the transmit clock_tolerance_fifo is counted in a clear-on-read tally.
// - Every idle inserted by the transmit clock_tolerance_fifo is counted in its own tally.
// - Every idle dropped by the receive clock_tolerance_fifo is counted in a clear-on-read tally.
// - Every idle inserted by the receive clock_tolerance_fifo is counted in a clear-on-read tally.
// - All tallies reset to 0xFFFD and the status word resets to 0x0000.
// - Status bit 15 follows the live transmit pattern lock without latching.
// - Status bit 5 latches high on an invalid start column until the host reads it.
// - Status bit 4 latches high on an invalid terminate column until the host reads it.
// - Status bits 3 to 0 latch high on an invalid character in lanes 3 to 0.
`timescale 1ns/1ps
`include "kxs_regs.svh"
module kxs_error_stats (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    output logic             mdioOut,
    output logic             mdioOe,
    input  wire logic [4:0]  portAddr,
    input  wire logic        colValid,
    input  wire logic [31:0] xgmiiData,
    input  wire logic [3:0]  xgmiiCtrl,
    input  wire logic        txIdleDrop,
    input  wire logic        txIdleInsert,
    input  wire logic        rxIdleDrop,
    input  wire logic        rxIdleInsert,
    input  wire logic        txPatternLock,
    input  wire logic        invalidStartCol,
    input  wire logic        invalidTermCol,
    input  wire logic [3:0]  badChar
);
    import kxs_pkg::*;

    // pin synchronisation
    logic                        mdcS, mdioS, mdcPrev, mdcRise;
    logic [4:0]                  portAddrS;

    // column checks
    logic                        term2, term3, lane3IsK, allK, allA, colIsKA;
    logic                        pend2, pend2Bad, pend3, eopErr2, eopErr3;

    // tallies and status
    logic [`KXS_NUM_TALLIES-1:0] tallyInc;
    logic [`KXS_NUM_TALLIES-1:0] tallyClr;
    kxs_word_t                   tally [`KXS_NUM_TALLIES];
    kxs_word_t                   lane2PacketEndErrorTally, lane3PacketEndErrorTally;
    kxs_word_t                   txIdleDropTally, txIdleInsertTally;
    kxs_word_t                   rxIdleDropTally, rxIdleInsertTally;
    logic [5:0]                  lhFlags, lhEvents;
    logic                        clrStatus;
    kxs_word_t                   statusWord, regMux;

    // management frame engine
    kxs_mdio_state_t             state;
    logic [5:0]                  onesCnt;
    logic [3:0]                  bitCnt;
    logic [13:0]                 hdr, hdrNext;
    logic                        hdrDone, hdrMatch, frameMatch, reading, rdPulse, frameEnd;
    logic [1:0]                  frameOp;
    kxs_word_t                   dataShift, readShift, addrReg;

    function automatic logic laneIsK(input logic [7:0] d, input logic c);
        laneIsK = c && (d == `KXS_CODE_K || d == `KXS_CODE_IDLE);
    endfunction : laneIsK

    kxs_sync #(
        .WIDTH (7)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .asyncIn ({mdc, mdioIn, portAddr}),
        .syncOut ({mdcS, mdioS, portAddrS})
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdcPrev <= 1'b0;
        end else begin
            mdcPrev <= mdcS;
        end
    end

    assign mdcRise = mdcS && !mdcPrev;

    // column decode
    assign term2    = xgmiiCtrl[2] && xgmiiData[23:16] == `KXS_CODE_TERM;
    assign term3    = xgmiiCtrl[3] && xgmiiData[31:24] == `KXS_CODE_TERM;
    assign lane3IsK = laneIsK(xgmiiData[31:24], xgmiiCtrl[3]);

    always_comb begin
        allK = 1'b1;
        allA = 1'b1;
        for (int i = 0; i < 4; i++) begin
            allK = allK && laneIsK(xgmiiData[8*i +: 8], xgmiiCtrl[i]);
            allA = allA && xgmiiCtrl[i] && xgmiiData[8*i +: 8] == `KXS_CODE_A;
        end
    end

    assign colIsKA = allK || allA;

    // terminate seen, judged against the following column
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend2    <= 1'b0;
            pend2Bad <= 1'b0;
            pend3    <= 1'b0;
        end else if (colValid) begin
            pend2    <= term2;
            pend2Bad <= term2 && !lane3IsK;
            pend3    <= term3;
        end
    end

    assign eopErr2 = colValid && pend2 && (pend2Bad || !colIsKA);
    assign eopErr3 = colValid && pend3 && !colIsKA;

    // tallies in register order
    assign tallyInc = {rxIdleInsert, rxIdleDrop, txIdleInsert, txIdleDrop, eopErr3, eopErr2};

    genvar g;
    generate
        for (g = 0; g < `KXS_NUM_TALLIES; g++) begin : g_tally
            assign tallyClr[g] = rdPulse && addrReg == (`KXS_ADDR_LN2_EOP + 16'(g));

            kxs_sat_counter u_cnt (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .inc     (tallyInc[g]),
                .clr     (tallyClr[g]),
                .count   (tally[g])
            );
        end
    endgenerate

    assign lane2PacketEndErrorTally = tally[0];
    assign lane3PacketEndErrorTally = tally[1];
    assign txIdleDropTally          = tally[2];
    assign txIdleInsertTally        = tally[3];
    assign rxIdleDropTally          = tally[4];
    assign rxIdleInsertTally        = tally[5];

    // latched-high flags, set wins over the read clear
    assign lhEvents  = {invalidStartCol, invalidTermCol, badChar};
    assign clrStatus = rdPulse && addrReg == `KXS_ADDR_STATUS;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lhFlags <= 6'(`KXS_STATUS_RESET);
        end else begin
            lhFlags <= (clrStatus ? 6'h00 : lhFlags) | lhEvents;
        end
    end

    always_comb begin
        statusWord                                   = `KXS_STATUS_RESET;
        statusWord[`KXS_ST_SYNC_BIT]                 = txPatternLock;
        statusWord[`KXS_ST_RSVD_HI:`KXS_ST_RSVD_LO]  = 9'h000;
        statusWord[`KXS_ST_SCOL_BIT:0]               = lhFlags;
    end

    always_comb begin
        case (addrReg)
            `KXS_ADDR_LN2_EOP:   regMux = lane2PacketEndErrorTally;
            `KXS_ADDR_LN3_EOP:   regMux = lane3PacketEndErrorTally;
            `KXS_ADDR_TX_DROP:   regMux = txIdleDropTally;
            `KXS_ADDR_TX_INSERT: regMux = txIdleInsertTally;
            `KXS_ADDR_RX_DROP:   regMux = rxIdleDropTally;
            `KXS_ADDR_RX_INSERT: regMux = rxIdleInsertTally;
            `KXS_ADDR_STATUS:    regMux = statusWord;
            default:             regMux = `KXS_UNMAPPED_DATA;
        endcase
    end

    // management frame: preamble, header, turnaround, data
    assign hdrNext  = {hdr[12:0], mdioS};
    assign hdrDone  = mdcRise && state == MDIO_HDR && bitCnt == `KXS_HDR_LAST;
    assign hdrMatch = hdrNext[13:12] == 2'h0 && hdrNext[9:5] == portAddrS
                      && hdrNext[4:0] == `KXS_DEVAD;
    assign rdPulse  = hdrDone && hdrMatch
                      && (hdrNext[11:10] == `KXS_OP_READ || hdrNext[11:10] == `KXS_OP_READ_INC);
    assign frameEnd = mdcRise && state == MDIO_DATA && bitCnt == `KXS_DATA_LAST;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= MDIO_PRE;
            onesCnt    <= 6'h00;
            bitCnt     <= 4'h0;
            hdr        <= 14'h0000;
            frameMatch <= 1'b0;
            frameOp    <= 2'h0;
            dataShift  <= 16'h0000;
        end else if (mdcRise) begin
            case (state)
                MDIO_PRE: begin
                    if (mdioS) begin
                        if (onesCnt != `KXS_PREAMBLE_LEN) begin
                            onesCnt <= onesCnt + 6'h01;
                        end
                    end else if (onesCnt == `KXS_PREAMBLE_LEN) begin
                        state  <= MDIO_HDR;
                        hdr    <= 14'h0000;
                        bitCnt <= 4'h1;
                    end else begin
                        onesCnt <= 6'h00;
                    end
                end
                MDIO_HDR: begin
                    hdr    <= hdrNext;
                    bitCnt <= bitCnt + 4'h1;
                    if (bitCnt == `KXS_HDR_LAST) begin
                        state      <= MDIO_TA;
                        bitCnt     <= 4'h0;
                        frameMatch <= hdrMatch;
                        frameOp    <= hdrNext[11:10];
                    end
                end
                MDIO_TA: begin
                    bitCnt <= bitCnt + 4'h1;
                    if (bitCnt == 4'h1) begin
                        state  <= MDIO_DATA;
                        bitCnt <= 4'h0;
                    end
                end
                MDIO_DATA: begin
                    dataShift <= {dataShift[14:0], mdioS};
                    bitCnt    <= bitCnt + 4'h1;
                    if (bitCnt == `KXS_DATA_LAST) begin
                        state   <= MDIO_PRE;
                        onesCnt <= 6'h00;
                        bitCnt  <= 4'h0;
                    end
                end
                default: begin
                    state <= MDIO_PRE;
                end
            endcase
        end
    end

    // address frames load the pointer; writes change nothing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addrReg <= 16'h0000;
        end else if (frameEnd && frameMatch) begin
            if (frameOp == `KXS_OP_ADDR) begin
                addrReg <= {dataShift[14:0], mdioS};
            end else if (frameOp == `KXS_OP_READ_INC) begin
                addrReg <= addrReg + 16'h0001;
            end
        end
    end

    // read data captured in the clearing cycle, shifted out msb first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readShift <= 16'h0000;
            reading   <= 1'b0;
            mdioOut   <= 1'b0;
            mdioOe    <= 1'b0;
        end else if (rdPulse) begin
            readShift <= regMux;
            reading   <= 1'b1;
        end else if (mdcRise && reading) begin
            if (state == MDIO_TA && bitCnt == 4'h0) begin
                mdioOe  <= 1'b1;
                mdioOut <= 1'b0;
            end else if (frameEnd) begin
                mdioOe  <= 1'b0;
                mdioOut <= 1'b0;
                reading <= 1'b0;
            end else begin
                mdioOut   <= readShift[15];
                readShift <= {readShift[14:0], 1'b0};
            end
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_lane2_count;
        eopErr2 && !tallyClr[0] && lane2PacketEndErrorTally != `KXS_TALLY_MAX
        |=> lane2PacketEndErrorTally == $past(lane2PacketEndErrorTally) + 16'h0001;
    endproperty
    a_lane2_count: assert property (p_lane2_count)
        else $error("lane 2 tally did not advance on an end error");
    property p_lane2_nonk;
        colValid && term2 && !lane3IsK ##1 colValid && !tallyClr[0]
            && lane2PacketEndErrorTally != `KXS_TALLY_MAX
        |=> lane2PacketEndErrorTally == $past(lane2PacketEndErrorTally) + 16'h0001;
    endproperty
    a_lane2_nonk: assert property (p_lane2_nonk)
        else $error("terminate in lane 2 without K after it was not counted");
    property p_lane3_good;
        colValid && pend3 && colIsKA && !tallyClr[1]
        |=> lane3PacketEndErrorTally == $past(lane3PacketEndErrorTally);
    endproperty
    a_lane3_good: assert property (p_lane3_good)
        else $error("lane 3 tally moved although next column was K or A");
    property p_cor_value;
        rdPulse && addrReg == `KXS_ADDR_LN2_EOP
        |=> readShift == $past(lane2PacketEndErrorTally) && lane2PacketEndErrorTally <= 16'h0001;
    endproperty
    a_cor_value: assert property (p_cor_value)
        else $error("lane 2 read did not return old value and clear");
    property p_tx_drop;
        txIdleDrop && !tallyClr[2] && txIdleDropTally != `KXS_TALLY_MAX
        |=> txIdleDropTally == $past(txIdleDropTally) + 16'h0001;
    endproperty
    a_tx_drop: assert property (p_tx_drop)
        else $error("transmit idle drop not counted");
    property p_tx_insert;
        txIdleInsert && !tallyClr[3] && txIdleInsertTally != `KXS_TALLY_MAX
        |=> txIdleInsertTally == $past(txIdleInsertTally) + 16'h0001;
    endproperty
    a_tx_insert: assert property (p_tx_insert)
        else $error("transmit idle insert not counted");
    property p_rx_drop;
        rxIdleDrop && !tallyClr[4] && rxIdleDropTally != `KXS_TALLY_MAX
        |=> rxIdleDropTally == $past(rxIdleDropTally) + 16'h0001;
    endproperty
    a_rx_drop: assert property (p_rx_drop)
        else $error("receive idle drop not counted");
    property p_rx_insert;
        rxIdleInsert && !tallyClr[5] && rxIdleInsertTally != `KXS_TALLY_MAX
        |=> rxIdleInsertTally == $past(rxIdleInsertTally) + 16'h0001;
    endproperty
    a_rx_insert: assert property (p_rx_insert)
        else $error("receive idle insert not counted");
    property p_status_read;
        rdPulse && addrReg == `KXS_ADDR_STATUS
        |=> readShift[15] == $past(txPatternLock) && readShift[14:6] == 9'h000;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read gave wrong lock or reserved bits");
    property p_start_latch;
        invalidStartCol |=> lhFlags[5] [*1] ##1 (lhFlags[5] || $past(clrStatus));
    endproperty
    a_start_latch: assert property (p_start_latch)
        else $error("invalid start flag did not latch");
    property p_term_latch;
        invalidTermCol ##1 !clrStatus |=> lhFlags[4];
    endproperty
    a_term_latch: assert property (p_term_latch)
        else $error("invalid terminate flag did not hold");
    property p_char_latch;
        badChar != 4'h0 |=> (lhFlags[3:0] & $past(badChar)) == $past(badChar);
    endproperty
    a_char_latch: assert property (p_char_latch)
        else $error("invalid character flag did not latch");
    property p_saturate;
        txIdleDropTally == `KXS_TALLY_MAX && !tallyClr[2] |=> txIdleDropTally == `KXS_TALLY_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("tally wrapped past all ones");

endmodule : kxs_error_stats

// ===== tb/kxs_mdio_host.sv
// Purpose: behavioural management host that clocks clause 45 frames
// Assumes: wire level is resolved by the bench with a pull-up
// Notes:   changes happen on sysClk falling edges only
`timescale 1ns/1ps
module kxs_mdio_host #(
    parameter int HALF = 8
) (
    input  wire logic sysClk,
    output logic      mdc,
    output logic      hostOut,
    output logic      hostOe,
    input  wire logic mdio
);
    initial begin
        mdc = 1'b0;
        hostOut = 1'b1;
        hostOe = 1'b0;
    end

    task automatic frame(input logic [1:0] op, input logic [4:0] prt,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, 2'h0, op, prt, 5'h01, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            @(negedge sysClk);
            mdc = 1'b0;
            // turnaround and data left to the device on reads
            hostOe = !(op[1] && i >= 46);
            hostOut = f[63-i];
            repeat (HALF) @(negedge sysClk);
            if (i >= 48) rd[63-i] = mdio;
            mdc = 1'b1;
            repeat (HALF) @(negedge sysClk);
        end
        mdc = 1'b0;
        hostOe = 1'b0;
    endtask : frame
endmodule : kxs_mdio_host

// ===== tb/kxs_error_stats_bench.sv
// Purpose: self-checking bench of the error statistics bank
// Assumes: register access only through management frames
// Notes:   released management wire floats high through a pull-up
`timescale 1ns/1ps
`include "kxs_regs.svh"
module kxs_error_stats_bench;
    import kxs_pkg::*;
    localparam logic [4:0] PORT = 5'h0A;
    logic        sysClk = 1'b0;
    logic        rstN;
    logic        mdc, hostOut, hostOe, mdioOut, mdioOe;
    logic        colValid, txPatternLock, invalidStartCol, invalidTermCol;
    logic        txIdleDrop, txIdleInsert, rxIdleDrop, rxIdleInsert;
    logic [31:0] xgmiiData;
    logic [3:0]  xgmiiCtrl, badChar;
    wire         mdioWire;
    kxs_word_t   got;
    int          errCount = 0;
    int          nTests = 0;

    assign mdioWire = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);
    always #5 sysClk = ~sysClk;

    kxs_mdio_host i_host (.sysClk(sysClk), .mdc(mdc), .hostOut(hostOut),
                          .hostOe(hostOe), .mdio(mdioWire));
    kxs_error_stats i_dut (
        .sys_clk(sysClk), .rst_n(rstN), .mdc(mdc), .mdioIn(mdioWire),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .portAddr(PORT),
        .colValid(colValid), .xgmiiData(xgmiiData), .xgmiiCtrl(xgmiiCtrl),
        .txIdleDrop(txIdleDrop), .txIdleInsert(txIdleInsert),
        .rxIdleDrop(rxIdleDrop), .rxIdleInsert(rxIdleInsert),
        .txPatternLock(txPatternLock), .invalidStartCol(invalidStartCol),
        .invalidTermCol(invalidTermCol), .badChar(badChar));

    task automatic chk(input kxs_word_t g, input kxs_word_t e);
        nTests++;
        if (g !== e) begin
            errCount++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic setAddr(input kxs_word_t a);
        i_host.frame(`KXS_OP_ADDR, PORT, a, got);
    endtask : setAddr

    task automatic rd(input logic [1:0] op, input kxs_word_t e);
        i_host.frame(op, PORT, 16'h0000, got);
        chk(got, e);
    endtask : rd

    // separated one-cycle pulses, a to d per idle event input
    task automatic ev(input int a, input int b, input int c, input int d);
        for (int i = 0; i < 12; i++) begin
            @(negedge sysClk);
            txIdleDrop = (i % 2 == 0) && (i / 2 < a);
            txIdleInsert = (i % 2 == 0) && (i / 2 < b);
            rxIdleDrop = (i % 2 == 0) && (i / 2 < c);
            rxIdleInsert = (i % 2 == 0) && (i / 2 < d);
        end
    endtask : ev

    task automatic col(input logic [31:0] d, input logic [3:0] c);
        @(negedge sysClk);
        colValid = 1'b1;
        xgmiiData = d;
        xgmiiCtrl = c;
    endtask : col

    task automatic testResetValues();
        ev(3, 0, 0, 0);
        setAddr(`KXS_ADDR_LN2_EOP);
        for (int i = 0; i < 7; i++) begin
            rd(`KXS_OP_READ_INC, i == 2 ? 16'hFFFF : (i == 6 ? 16'h0000 : 16'hFFFD));
        end
        setAddr(`KXS_ADDR_LN2_EOP);
        for (int i = 0; i < 6; i++) begin
            rd(`KXS_OP_READ_INC, 16'h0000);
        end
    endtask : testResetValues

    task automatic testIdle();
        ev(2, 3, 4, 5);
        setAddr(`KXS_ADDR_TX_DROP);
        for (int i = 0; i < 4; i++) begin
            rd(`KXS_OP_READ_INC, kxs_word_t'(i + 2));
        end
    endtask : testIdle

    task automatic testEop();
        col(32'h07FD5566, 4'hC);
        col(32'h07070707, 4'hF);
        col(32'h07FD5566, 4'hC);
        col(32'h11223344, 4'h0);
        col(32'h99FD5566, 4'h4);
        col(32'hBCBCBCBC, 4'hF);
        col(32'hFD112233, 4'h8);
        col(32'h7C7C7C7C, 4'hF);
        col(32'hFD112233, 4'h8);
        col(32'h11223344, 4'h0);
        col(32'h07070707, 4'hF);
        @(negedge sysClk);
        colValid = 1'b0;
        setAddr(`KXS_ADDR_LN2_EOP);
        rd(`KXS_OP_READ_INC, 16'h0002);
        rd(`KXS_OP_READ_INC, 16'h0001);
    endtask : testEop

    task automatic testStatus();
        @(negedge sysClk);
        txPatternLock = 1'b1;
        {invalidStartCol, invalidTermCol, badChar} = 6'h3A;
        @(negedge sysClk);
        {invalidStartCol, invalidTermCol, badChar} = 6'h00;
        setAddr(`KXS_ADDR_STATUS);
        rd(`KXS_OP_READ, 16'h803A);
        txPatternLock = 1'b0;
        i_host.frame(`KXS_OP_WRITE, PORT, 16'hFFFF, got);
        rd(`KXS_OP_READ, 16'h0000);
        @(negedge sysClk);
        badChar = 4'h1;
        @(negedge sysClk);
        badChar = 4'h0;
        // wrong port: nobody drives, the pull-up is read
        i_host.frame(`KXS_OP_READ, 5'h0B, 16'h0000, got);
        chk(got, 16'hFFFF);
        rd(`KXS_OP_READ, 16'h0001);
        setAddr(16'h8020);
        rd(`KXS_OP_READ, `KXS_UNMAPPED_DATA);
    endtask : testStatus

    task automatic testDone();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : testDone

    initial begin
        rstN = 1'b0;
        {colValid, txIdleDrop, txIdleInsert, rxIdleDrop, rxIdleInsert} = 5'h00;
        {txPatternLock, invalidStartCol, invalidTermCol} = 3'h0;
        xgmiiData = 32'h07070707;
        xgmiiCtrl = 4'hF;
        badChar = 4'h0;
        repeat (6) @(negedge sysClk);
        rstN = 1'b1;
        repeat (4) @(negedge sysClk);
        testResetValues();
        testIdle();
        testEop();
        testStatus();
        testDone();
    end

    initial begin
        repeat (60000) @(posedge sysClk);
        errCount++;
        testDone();
    end
endmodule : kxs_error_stats_bench
